//--- common/sto_pkg.sv
// Constants for the torque-off sequencer: timing figures and derived counts.
// Assumes a 10 MHz clock and a 1 ms tick from the divider.
package sto_pkg;
  localparam int unsigned CLK_HZ            = 10_000_000;
  localparam int unsigned TICK_US           = 1000;
  localparam int unsigned TICK_CYCLES       = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned BOOT_MS           = 4000;
  localparam int unsigned DC_CHARGE_MS      = 1000;
  localparam int unsigned STAGE_ON_MS       = 6;
  localparam int unsigned MAINS_LOSS_MS     = 600;
  localparam int unsigned MISMATCH_MS       = 100;
  localparam int unsigned HOLD_LOW_MS       = 20;
  localparam int unsigned DELAY_MAX_MS      = 32000;
  localparam int unsigned FILTER_LEN        = 4;
  localparam int unsigned POS_CYCLE_US      = 200;
  localparam int unsigned POS_CYCLE_CYCLES  = CLK_HZ / 1_000_000 * POS_CYCLE_US;
  localparam int unsigned TW                = 16;
  typedef enum logic [2:0] {
    STO_BOOT, STO_CHARGE, STO_READY, STO_STAGE_WAIT, STO_START_WAIT,
    STO_RUN, STO_STOP_WAIT, STO_SAFE_OFF
  } sto_state_t;
endpackage : sto_pkg

//--- core/sto_timer.sv
// Millisecond down-counter, loaded on start, counts on the tick enable.
// Assumes the tick is a one-cycle pulse from the parent divider.
`timescale 1ns/1ps
`default_nettype none
module sto_timer #(
  parameter int unsigned W = 16
) (
  input  wire logic         ref_clk_in,
  input  wire logic         rst_n_in,
  input  wire logic         start_in,
  input  wire logic [W-1:0] load_in,
  input  wire logic         tick_in,
  output logic              done_out
);
  logic [W-1:0] cnt_q;
  logic         run_q;

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end else if (start_in) begin
      cnt_q <= load_in;
      run_q <= 1'b1;
    end else if (run_q && (cnt_q == '0)) begin
      run_q <= 1'b0;
    end else if (run_q && tick_in) begin
      cnt_q <= cnt_q - W'(1);
    end
  end

  assign done_out = run_q && (cnt_q == '0);
endmodule : sto_timer
`default_nettype wire

//--- core/sto_sequencer.sv
// Power-on and torque-off sequencer for a servo drive output stage.
// Assumes all inputs synchronous to ref_clk_in; firmware and mains status
// arrive as plain levels, delays in milliseconds.
`timescale 1ns/1ps
`default_nettype none
module sto_sequencer
  import sto_pkg::*;
#(
  parameter int unsigned TICK_DIV   = sto_pkg::TICK_CYCLES,
  parameter int unsigned FILT_DIV   = sto_pkg::POS_CYCLE_CYCLES,
  parameter int unsigned CHARGE_MS  = sto_pkg::DC_CHARGE_MS,
  parameter int unsigned BOOT_LIM   = sto_pkg::BOOT_MS,
  parameter int unsigned MAINS_MS   = sto_pkg::MAINS_LOSS_MS
) (
  input  wire logic                   ref_clk_in,
  input  wire logic                   rst_n_in,
  input  wire logic                   firmware_ready_in,
  input  wire logic                   mains_present_in,
  input  wire logic                   torque_off_channel_a_in,
  input  wire logic                   torque_off_channel_b_in,
  input  wire logic                   drive_enable_input_in,
  input  wire logic [sto_pkg::TW-1:0] start_delay_ms_in,
  input  wire logic [sto_pkg::TW-1:0] stop_delay_ms_in,
  input  wire logic                   error_clear_in,
  output logic                        power_stage_on_out,
  output logic                        brake_release_out,
  output logic                        setpoint_enable_out,
  output logic                        dc_bus_ready_out,
  output logic                        mains_lost_out,
  output logic                        boot_timeout_out,
  output logic                        mismatch_error_out,
  output logic                        sto_active_error_out,
  output logic                        safe_off_out,
  output logic [2:0]                  state_out
);
  import sto_pkg::*;

  sto_state_t   state_q;
  logic [31:0]  div_q;
  logic         tick_q;
  logic [31:0]  fdiv_q;
  logic [FILTER_LEN-1:0] fsh_q;
  logic         enable_q;
  logic         both_high, both_low, differ;
  logic [TW-1:0] boot_cnt_q, mains_cnt_q, mis_cnt_q, hold_cnt_q;
  logic         hold_ok_q;
  logic         t_start, t_done;
  logic [TW-1:0] t_load;

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else if (div_q == TICK_DIV - 1) begin
      div_q  <= '0;
      tick_q <= 1'b1;
    end else begin
      div_q  <= div_q + 32'h1;
      tick_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fdiv_q   <= '0;
      fsh_q    <= '0;
      enable_q <= 1'b0;
    end else if (fdiv_q == FILT_DIV - 1) begin
      fdiv_q <= '0;
      fsh_q  <= {fsh_q[FILTER_LEN-2:0], drive_enable_input_in};
      if (&fsh_q) begin
        enable_q <= 1'b1;
      end else if (~|fsh_q) begin
        enable_q <= 1'b0;
      end
    end else begin
      fdiv_q <= fdiv_q + 32'h1;
    end
  end

  assign both_high = torque_off_channel_a_in & torque_off_channel_b_in;
  assign both_low  = ~(torque_off_channel_a_in | torque_off_channel_b_in);
  assign differ    = torque_off_channel_a_in ^ torque_off_channel_b_in;

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mis_cnt_q          <= '0;
      mismatch_error_out <= 1'b0;
    end else begin
      if (!differ) begin
        mis_cnt_q <= '0;
      end else if (tick_q && mis_cnt_q <= TW'(MISMATCH_MS)) begin
        mis_cnt_q <= mis_cnt_q + TW'(1);
      end
      // Set wins over a clear in the same cycle
      if (differ && mis_cnt_q > TW'(MISMATCH_MS)) begin
        mismatch_error_out <= 1'b1;
      end else if (error_clear_in) begin
        mismatch_error_out <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      boot_cnt_q       <= '0;
      boot_timeout_out <= 1'b0;
    end else if (!firmware_ready_in && tick_q) begin
      if (boot_cnt_q >= TW'(BOOT_LIM - 1)) begin
        boot_timeout_out <= 1'b1;
      end else begin
        boot_cnt_q <= boot_cnt_q + TW'(1);
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mains_cnt_q    <= '0;
      mains_lost_out <= 1'b0;
    end else if (mains_present_in) begin
      mains_cnt_q    <= '0;
      mains_lost_out <= 1'b0;
    end else if (tick_q) begin
      if (mains_cnt_q >= TW'(MAINS_MS - 1)) begin
        mains_lost_out <= 1'b1;
      end else begin
        mains_cnt_q <= mains_cnt_q + TW'(1);
      end
    end
  end

  // Enable must stay low over 20 ms after restore
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hold_cnt_q <= '0;
      hold_ok_q  <= 1'b0;
    end else if (enable_q || !both_high) begin
      hold_cnt_q <= '0;
      hold_ok_q  <= 1'b0;
    end else if (tick_q) begin
      if (hold_cnt_q > TW'(HOLD_LOW_MS)) begin
        hold_ok_q <= 1'b1;
      end else begin
        hold_cnt_q <= hold_cnt_q + TW'(1);
      end
    end
  end

  // Shared sequence timer; one phase is timed at a time
  sto_timer #(
    .W (TW)
  ) u_timer (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n_in),
    .start_in   (t_start),
    .load_in    (t_load),
    .tick_in    (tick_q),
    .done_out   (t_done)
  );

  // Clamp programmed delays to 32 s
  function automatic logic [TW-1:0] clamp_ms(input logic [TW-1:0] v);
    clamp_ms = (v > TW'(DELAY_MAX_MS)) ? TW'(DELAY_MAX_MS) : v;
  endfunction : clamp_ms

  always_comb begin
    t_start  = 1'b0;
    t_load   = '0;
    unique case (state_q)
      STO_BOOT: begin
        t_start = firmware_ready_in && mains_present_in;
        t_load  = TW'(CHARGE_MS);
      end
      STO_READY: begin
        t_start = enable_q && both_high;
        t_load  = TW'(STAGE_ON_MS);
      end
      STO_STAGE_WAIT: begin
        t_start = t_done;
        t_load  = clamp_ms(start_delay_ms_in);
      end
      // Enable lost before the run: the stop delay still applies
      STO_START_WAIT: begin
        t_start = !enable_q;
        t_load  = clamp_ms(stop_delay_ms_in);
      end
      STO_RUN: begin
        t_start = !enable_q && both_high;
        t_load  = clamp_ms(stop_delay_ms_in);
      end
      default: begin
        t_start = 1'b0;
      end
    endcase
  end

  // Main sequence; torque-off overrides every state except STO_BOOT and STO_CHARGE
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= STO_BOOT;
    end else if (!both_high && state_q != STO_BOOT
                 && state_q != STO_CHARGE) begin
      state_q <= STO_SAFE_OFF;
    end else begin
      unique case (state_q)
        STO_BOOT:       if (t_start) state_q <= STO_CHARGE;
        STO_CHARGE:     if (t_done) state_q <= STO_SAFE_OFF;
        STO_READY:      if (t_start) state_q <= STO_STAGE_WAIT;
        STO_STAGE_WAIT: if (!enable_q) state_q <= STO_READY;
                        else if (t_done) state_q <= STO_START_WAIT;
        STO_START_WAIT: if (!enable_q) state_q <= STO_STOP_WAIT;
                        else if (t_done) state_q <= STO_RUN;
        STO_RUN:        if (t_start) state_q <= STO_STOP_WAIT;
        STO_STOP_WAIT:  if (t_done) state_q <= STO_READY;
        // Restore is seen only once hold_ok_q is set, over 20 ms after restore with enable low
        STO_SAFE_OFF:   if (both_high && hold_ok_q) state_q <= STO_READY;
      endcase
    end
  end

  // Outputs lag the state by one cycle only
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      power_stage_on_out  <= 1'b0;
      brake_release_out   <= 1'b0;
      setpoint_enable_out <= 1'b0;
      dc_bus_ready_out    <= 1'b0;
      safe_off_out        <= 1'b1;
      state_out           <= '0;
    end else begin
      power_stage_on_out  <= both_high &&
                             (state_q == STO_START_WAIT ||
                              state_q == STO_RUN ||
                              state_q == STO_STOP_WAIT);
      brake_release_out   <= both_high &&
                             (state_q == STO_START_WAIT ||
                              state_q == STO_RUN);
      setpoint_enable_out <= both_high && state_q == STO_RUN;
      dc_bus_ready_out    <= state_q != STO_BOOT && state_q != STO_CHARGE;
      safe_off_out        <= !both_high;
      state_out           <= state_q;
    end
  end

  // Error when channels drop under an active stage
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sto_active_error_out <= 1'b0;
    end else if (!both_high && power_stage_on_out) begin
      sto_active_error_out <= 1'b1;
    end else if (error_clear_in) begin
      sto_active_error_out <= 1'b0;
    end
  end

endmodule : sto_sequencer
`default_nettype wire

//--- tb/sto_partner.sv
// Model of the safety relay and the motion controller.
// Assumes requests from the bench change on falling edges by <=.
`timescale 1ns/1ps
`default_nettype none
module sto_partner #(
  parameter int unsigned HOLD_CYC = 250
) (
  input  wire logic ref_clk_in,
  input  wire logic req_a_in,
  input  wire logic req_b_in,
  input  wire logic req_en_in,
  output logic      chan_a_out,
  output logic      chan_b_out,
  output logic      enable_out
);
  logic        a_q = 1'b1;
  logic        b_q = 1'b1;
  logic        en_q = 1'b0;
  logic        ok_q = 1'b0;
  logic [15:0] low_q = 16'h0;
  assign chan_a_out = a_q;
  assign chan_b_out = b_q;
  assign enable_out = en_q;
  // Channels move on command only, no test pulses
  always @(negedge ref_clk_in) begin
    a_q <= req_a_in;
    b_q <= req_b_in;
  end
  // Enable kept low after channels restored
  always @(negedge ref_clk_in) begin
    if (!(req_a_in && req_b_in)) begin
      ok_q <= 1'b0;
      low_q <= 16'h0;
    end else if (low_q > HOLD_CYC) begin
      ok_q <= 1'b1;
    end else begin
      low_q <= low_q + 16'h1;
    end
    en_q <= req_en_in && ok_q;
  end
endmodule : sto_partner
`default_nettype wire

//--- tb/sto_sequencer_properties.sv
// Port-level checker for the torque-off sequencer.
// Assumes the bind hands on the sequencer's tick divider.
`timescale 1ns/1ps
`default_nettype none
module sto_seq_chk #(
  parameter int unsigned TICK_DIV = 10
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic mains_present_in,
  input wire logic torque_off_channel_a_in,
  input wire logic torque_off_channel_b_in,
  input wire logic drive_enable_input_in,
  input wire logic power_stage_on_out,
  input wire logic brake_release_out,
  input wire logic setpoint_enable_out,
  input wire logic dc_bus_ready_out,
  input wire logic mains_lost_out,
  input wire logic mismatch_error_out,
  input wire logic sto_active_error_out
);
  logic        both_w;
  logic [15:0] mm_q;
  logic [15:0] en_q;
  assign both_w = torque_off_channel_a_in & torque_off_channel_b_in;
  // Run lengths saturate so a long soak cannot wrap them
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mm_q <= 16'h0;
      en_q <= 16'h0;
    end else begin
      mm_q <= (torque_off_channel_a_in == torque_off_channel_b_in) ? 16'h0
            : mm_q + {15'h0, mm_q != 16'hffff};
      en_q <= !drive_enable_input_in ? 16'h0
            : en_q + {15'h0, en_q != 16'hffff};
    end
  end
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_drop_live;
    power_stage_on_out && !both_w;
  endsequence
  a_drop_stage_off: assert property (!both_w |=> !power_stage_on_out)
    else $error("stage on after channel drop");
  a_drop_live_err: assert property (s_drop_live |=> sto_active_error_out)
    else $error("no error for drop with stage on");
  a_mismatch_early: assert property ($rose(mismatch_error_out)
    |-> mm_q >= 99 * TICK_DIV) else $error("mismatch flagged too early");
  a_mismatch_late: assert property (mm_q == 103 * TICK_DIV
    |-> mismatch_error_out) else $error("mismatch flag missing");
  a_stage_on_wait: assert property ($rose(power_stage_on_out)
    |-> en_q >= 5 * TICK_DIV) else $error("stage on too soon");
  a_setpoint_gate: assert property (setpoint_enable_out
    |-> power_stage_on_out && brake_release_out)
    else $error("setpoint without stage and brake");
  a_stage_bus_ok: assert property (power_stage_on_out |-> dc_bus_ready_out)
    else $error("stage on before bus charged");
  a_mains_cause: assert property ($rose(mains_lost_out)
    |-> !$past(mains_present_in)) else $error("mains loss without cause");
endmodule : sto_seq_chk
bind sto_sequencer sto_seq_chk #(.TICK_DIV(TICK_DIV)) i_sto_seq_chk (
  .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
  .mains_present_in(mains_present_in),
  .torque_off_channel_a_in(torque_off_channel_a_in),
  .torque_off_channel_b_in(torque_off_channel_b_in),
  .drive_enable_input_in(drive_enable_input_in),
  .power_stage_on_out(power_stage_on_out),
  .brake_release_out(brake_release_out),
  .setpoint_enable_out(setpoint_enable_out),
  .dc_bus_ready_out(dc_bus_ready_out), .mains_lost_out(mains_lost_out),
  .mismatch_error_out(mismatch_error_out),
  .sto_active_error_out(sto_active_error_out));
`default_nettype wire

//--- tb/tb_safe_torque_off_sequencer.sv
// Self-checking bench for the torque-off sequencer with its partner.
// Assumes short timing parameters: 10-cycle tick, 5-tick charge and mains.
`timescale 1ns/1ps
`default_nettype none
module tb_safe_torque_off_sequencer;
  localparam int TK = 10;
  logic clk = 1'b0, rst_n = 1'b0, fw = 1'b0, mains = 1'b1, clr = 1'b0;
  logic ra = 1'b1, rb = 1'b1, ren = 1'b0, cha, chb, en;
  logic [15:0] sdly = 16'h0, pdly = 16'h0;
  logic stage, brake, spt, bus, mlost, boot_to, mm_err, sto_err, safe;
  logic [2:0] obs, st;
  int mismatches = 0, total_checks = 0;
  assign obs = {bus, spt, stage};
  initial forever #50 clk = ~clk;
  sto_partner #(.HOLD_CYC(25 * TK)) i_sto_partner (.ref_clk_in(clk),
    .req_a_in(ra), .req_b_in(rb), .req_en_in(ren), .chan_a_out(cha),
    .chan_b_out(chb), .enable_out(en));
  sto_sequencer #(.TICK_DIV(TK), .FILT_DIV(2), .CHARGE_MS(5),
    .BOOT_LIM(8), .MAINS_MS(5)) i_sto_sequencer (.ref_clk_in(clk),
    .rst_n_in(rst_n), .firmware_ready_in(fw), .mains_present_in(mains),
    .torque_off_channel_a_in(cha), .torque_off_channel_b_in(chb),
    .drive_enable_input_in(en), .start_delay_ms_in(sdly),
    .stop_delay_ms_in(pdly), .error_clear_in(clr),
    .power_stage_on_out(stage), .brake_release_out(brake),
    .setpoint_enable_out(spt), .dc_bus_ready_out(bus),
    .mains_lost_out(mlost), .boot_timeout_out(boot_to),
    .mismatch_error_out(mm_err), .sto_active_error_out(sto_err),
    .safe_off_out(safe), .state_out(st));
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask : chk
  // Bounded wait for one observed output to reach a level
  task automatic wait_lvl(input int k, input logic v, input int lim,
                          output int n);
    n = 0;
    while (obs[k] !== v && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (obs[k] !== v) begin
      mismatches++;
      print_verdict();
    end
  endtask : wait_lvl
  task automatic pulse_clear();
    @(negedge clk);
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
  endtask : pulse_clear
  task automatic t_boot(input logic f);
    int n;
    fw = f;
    rst_n = 1'b0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    if (!f) begin
      repeat (6 * TK) @(negedge clk);
      chk("boot_to_early", 1'b0, boot_to);
      repeat (4 * TK) @(negedge clk);
      chk("boot_to", 1'b1, boot_to);
    end else begin
      wait_lvl(2, 1'b1, 40 * TK, n);
      chk("charge_time", 1'b1, n >= 4 * TK);
      chk("boot_ok", 1'b0, boot_to);
      repeat (26 * TK) @(negedge clk);
      chk("state_ready", 1'b1, st === 3'h2);
    end
  endtask : t_boot
  task automatic t_run(input logic [15:0] s, input logic [15:0] p);
    int n;
    @(negedge clk);
    sdly = s;
    pdly = p;
    ren <= 1'b1;
    wait_lvl(0, 1'b1, 30 * TK, n);
    chk("stage_on_delay", 1'b1, n >= 5 * TK && n <= 9 * TK);
    chk("brake_release", 1'b1, brake);
    wait_lvl(1, 1'b1, 10 * TK, n);
    chk("start_delay", 1'b1, n + TK >= s * TK && n <= s * TK + 12);
    @(negedge clk);
    ren <= 1'b0;
    wait_lvl(0, 1'b0, 20 * TK, n);
    chk("stop_delay", 1'b1, n + TK >= p * TK);
  endtask : t_run
  task automatic t_drop(input logic da, input logic db);
    int n;
    @(negedge clk);
    ren <= 1'b1;
    wait_lvl(0, 1'b1, 30 * TK, n);
    ra <= da;
    rb <= db;
    repeat (2) @(negedge clk);
    chk("stage_off", 1'b0, stage);
    chk("sto_error", 1'b1, sto_err);
    chk("safe_off", 1'b1, safe);
    ra <= 1'b1;
    rb <= 1'b1;
    wait_lvl(0, 1'b1, 50 * TK, n);
    chk("restart_time", 1'b1, n >= 25 * TK && n <= 38 * TK);
    pulse_clear();
    chk("error_clear", 1'b0, sto_err);
    ren <= 1'b0;
    wait_lvl(0, 1'b0, 20 * TK, n);
  endtask : t_drop
  task automatic t_faults();
    @(negedge clk);
    ra <= 1'b0;
    repeat (50 * TK) @(negedge clk);
    ra <= 1'b1;
    @(negedge clk);
    chk("short_mismatch", 1'b0, mm_err);
    rb <= 1'b0;
    repeat (98 * TK) @(negedge clk);
    chk("mismatch_98", 1'b0, mm_err);
    repeat (5 * TK) @(negedge clk);
    chk("mismatch_103", 1'b1, mm_err);
    rb <= 1'b1;
    pulse_clear();
    chk("mismatch_clear", 1'b0, mm_err);
    mains = 1'b0;
    repeat (3 * TK) @(negedge clk);
    chk("mains_early", 1'b0, mlost);
    repeat (4 * TK) @(negedge clk);
    chk("mains_lost", 1'b1, mlost);
    mains = 1'b1;
    repeat (2) @(negedge clk);
    chk("mains_back", 1'b0, mlost);
  endtask : t_faults
  initial begin
    t_boot(1'b0);
    t_boot(1'b1);
    t_run(16'h3, 16'h2);
    t_drop(1'b0, 1'b1);
    t_drop(1'b1, 1'b0);
    t_run(16'h0, 16'h0);
    t_faults();
    print_verdict();
  end
endmodule : tb_safe_torque_off_sequencer
`default_nettype wire
